//--- design/regmap_checksum.sv
// Paged register map with signature check over the configuration page.
// Assumes the host drives one request per cycle; pins and nv values are synchronous.
// Notes on behaviour
// - Registers are 14 bits, 9-bit address
// - Page 1 measurements, page 3 commands
// - Signature skips measurement and command pages
// - Pages 4,5 internal except checksum words
// - Calculate command signs config page plus checksums
// - Check command recomputes and compares saved signature
// - Mismatch sets integrity fault, raises notification
// - Integrity fault halts scanning and balancing
// - Registers reinitialise on resetn and reset_cmd; the CMD_RESET command does nothing
// - NV bits load from memory, pin bits mirror
// - Reference checksum fixed at factory test
// - Reload recomputes checksum into second register
// - Ack, nak, single read: four bytes
// - Read all voltages: forty bytes
// - Read all temperatures or faults: 22 bytes
`timescale 1ns/100ps
module regmap_checksum (
   input  wire logic                             clk,
   input  wire logic                             resetn,
   input  wire logic                             reset_cmd,
   input  wire logic                             wr_en,
   input  wire logic [regmap_pkg::ADDR_W-1:0]    addr,
   input  wire logic [regmap_pkg::DATA_W-1:0]    wr_data,
   input  wire regmap_pkg::cmd_type              cmd,
   input  wire logic [regmap_pkg::DATA_W-1:0]    nv_ref_value,
   input  wire logic [regmap_pkg::DATA_W-1:0]    pin_levels,
   input  wire logic [regmap_pkg::DATA_W-1:0]    pin_mask,
   input  wire logic                             scan_req,
   input  wire logic                             balance_req,
   output logic      [regmap_pkg::DATA_W-1:0]    rd_data,
   output logic                                  rd_valid,
   output logic      [5:0]                       resp_len,
   output logic                                  resp_valid,
   output logic                                  nak,
   output logic                                  busy,
   output logic                                  register_integrity_fault_bit,
   output logic                                  fault_notify,
   output logic                                  scan_en,
   output logic                                  balance_en
);
   import regmap_pkg::*;

   typedef enum {ST_INIT, ST_IDLE, ST_WALK, ST_DONE} state_type;
   typedef enum logic [1:0] {JOB_RELOAD, JOB_CALC, JOB_CHECK} job_type;

   state_type         state_reg, state_next;        // Sequencer state
   job_type           job_reg, job_next;            // What the walk is for
   logic [8:0]        walk_reg, walk_next;          // Init and walk index
   logic [13:0]       misr_reg, misr_next;          // Running signature
   logic [13:0]       saved_reg, saved_next;        // Signature of last calculate
   logic              fault_reg, fault_next;        // Integrity fault flag
   logic              notify_reg, notify_next;      // One-cycle fault notification
   logic [5:0]        len_reg, len_next;            // Response length in bytes
   logic              rvalid_reg, rvalid_next;      // Response length strobe
   logic              nak_reg, nak_next;            // Refused request
   logic              rdv_reg, rdv_next;            // Read data strobe
   logic              scan_reg, scan_next;          // Scan allowed
   logic              bal_reg, bal_next;            // Balancing allowed
   logic              busy_reg, busy_next;          // Busy flag, registered so the output has no decode
   logic [13:0]       pin_reg, pin_next;            // Pin-derived bits
   logic              mem_we;
   logic [8:0]        mem_wa, mem_ra;
   logic [13:0]       mem_wd, mem_rd;
   logic              walk_last;

   regmap_mem u_mem (
      .clk     (clk),
      .wr_en   (mem_we),
      .wr_addr (mem_wa),
      .wr_data (mem_wd),
      .rd_addr (mem_ra),
      .rd_data (mem_rd)
   );

   // Walk covers the configuration page then both checksum words; read lags one cycle
   assign walk_last = (walk_reg == 9'(CONFIG_WORDS + 2));

   // Address the memory for the walk, or for host accesses
   always_comb begin
      mem_we = 1'b0;
      mem_wa = addr;
      mem_wd = wr_data;
      mem_ra = addr;
      if (state_reg == ST_INIT) begin
         mem_we = 1'b1;
         mem_wa = walk_reg;
         mem_wd = (walk_reg == ADDR_NV_REF) ? nv_ref_value : RESET_VALUE;
      end else if (state_reg == ST_WALK) begin
         // Config page words, then reference and computed checksum words
         if (walk_reg < 9'(CONFIG_WORDS)) begin
            mem_ra = {PAGE_CONFIG, walk_reg[5:0]};
         end else if (walk_reg == 9'(CONFIG_WORDS)) begin
            mem_ra = ADDR_NV_REF;
         end else begin
            mem_ra = ADDR_NV_CALC;
         end
         if (job_reg == JOB_RELOAD && walk_last) begin
            mem_we = 1'b1;
            mem_wa = ADDR_NV_CALC;
            mem_wd = misr_reg;
         end
      end else if (state_reg == ST_IDLE && wr_en) begin
         // Measurement, command and internal pages are not host writable; checksum words are read-only
         mem_we = (addr[8:6] == PAGE_CONFIG) && (addr != ADDR_NV_REF) && (addr != ADDR_NV_CALC);
      end
   end

   // Sequencer, signature and response next state
   always_comb begin
      state_next  = state_reg;
      job_next    = job_reg;
      walk_next   = walk_reg;
      misr_next   = misr_reg;
      saved_next  = saved_reg;
      fault_next  = fault_reg;
      notify_next = 1'b0;
      len_next    = len_reg;
      rvalid_next = 1'b0;
      nak_next    = 1'b0;
      rdv_next    = 1'b0;
      pin_next    = pin_levels & pin_mask;
      case (state_reg)
         ST_INIT: begin
            walk_next = walk_reg + 9'h001;
            if (walk_reg == 9'(DEPTH - 1)) begin
               // Shadow load done: compute the reload checksum
               state_next = ST_WALK;
               job_next   = JOB_RELOAD;
               walk_next  = '0;
               misr_next  = MISR_SEED;
            end
         end
         ST_IDLE: begin
            if (reset_cmd) begin
               state_next = ST_INIT;
               walk_next  = '0;
               fault_next = 1'b0;
            end else if (cmd == CMD_CALC || cmd == CMD_CHECK) begin
               state_next = ST_WALK;
               job_next   = (cmd == CMD_CALC) ? JOB_CALC : JOB_CHECK;
               walk_next  = '0;
               misr_next  = MISR_SEED;
            end else if (cmd == CMD_RD_ONE) begin
               rdv_next    = 1'b1;
               len_next    = RESP_ACK_LEN;
               rvalid_next = 1'b1;
            end else if (cmd == CMD_RD_VOLT) begin
               len_next    = RESP_VOLT_LEN;
               rvalid_next = 1'b1;
            end else if (cmd == CMD_RD_TEMP || cmd == CMD_RD_FAULT) begin
               len_next    = RESP_TEMP_LEN;
               rvalid_next = 1'b1;
            end else if (wr_en) begin
               // Ack for an accepted write, nak for a protected page
               len_next    = RESP_ACK_LEN;
               rvalid_next = 1'b1;
               nak_next    = (addr[8:6] != PAGE_CONFIG);
            end
         end
         ST_WALK: begin
            // Memory data for index k arrives at index k+1
            if (walk_reg != 9'h000) begin
               misr_next = {misr_reg[12:0], 1'b0} ^ (misr_reg[13] ? MISR_POLY : 14'h0000) ^ mem_rd;
            end
            walk_next = walk_reg + 9'h001;
            if (walk_last) begin
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            state_next = ST_IDLE;
            if (job_reg == JOB_CALC) begin
               saved_next = misr_reg;
            end else if (job_reg == JOB_CHECK && misr_reg != saved_reg) begin
               fault_next  = 1'b1;
               notify_next = 1'b1;
            end
            if (job_reg != JOB_RELOAD) begin
               len_next    = RESP_ACK_LEN;
               rvalid_next = 1'b1;
            end
         end
         default: begin
            state_next = ST_INIT;
            walk_next  = '0;
         end
      endcase
      // Any single host write to the configuration page clears the fault, unless one is raised now
      if (!notify_next && state_reg == ST_IDLE && wr_en && addr[8:6] == PAGE_CONFIG) begin
         fault_next = 1'b0;
      end
      scan_next = scan_req && !fault_next;
      bal_next  = balance_req && !fault_next;
      // Busy follows the state that the next edge loads
      busy_next = (state_next != ST_IDLE);
   end

   // Register all state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg  <= ST_INIT;
         job_reg    <= JOB_RELOAD;
         walk_reg   <= '0;
         misr_reg   <= MISR_SEED;
         saved_reg  <= MISR_SEED;
         fault_reg  <= 1'b0;
         notify_reg <= 1'b0;
         len_reg    <= '0;
         rvalid_reg <= 1'b0;
         nak_reg    <= 1'b0;
         rdv_reg    <= 1'b0;
         scan_reg   <= 1'b0;
         bal_reg    <= 1'b0;
         pin_reg    <= '0;
         busy_reg   <= 1'b1;
      end else begin
         state_reg  <= state_next;
         job_reg    <= job_next;
         walk_reg   <= walk_next;
         misr_reg   <= misr_next;
         saved_reg  <= saved_next;
         fault_reg  <= fault_next;
         notify_reg <= notify_next;
         len_reg    <= len_next;
         rvalid_reg <= rvalid_next;
         nak_reg    <= nak_next;
         rdv_reg    <= rdv_next;
         scan_reg   <= scan_next;
         bal_reg    <= bal_next;
         pin_reg    <= pin_next;
         busy_reg   <= busy_next;
      end
   end

   // Pin bits selected by pin_mask overlay memory reads
   always_comb begin
      rd_data = (mem_rd & ~pin_mask) | pin_reg;
   end

   assign rd_valid                     = rdv_reg;
   assign resp_len                     = len_reg;
   assign resp_valid                   = rvalid_reg;
   assign nak                          = nak_reg;
   assign busy                         = busy_reg;
   assign register_integrity_fault_bit = fault_reg;
   assign fault_notify                 = notify_reg;
   assign scan_en                      = scan_reg;
   assign balance_en                   = bal_reg;
endmodule // regmap_checksum

//--- design/regmap_mem.sv
// Register storage: one 14-bit word per 9-bit address, registered read data.
// Assumes one write or one read port access per cycle.
`timescale 1ns/100ps
module regmap_mem (
   input  wire logic                             clk,
   input  wire logic                             wr_en,
   input  wire logic [regmap_pkg::ADDR_W-1:0]    wr_addr,
   input  wire logic [regmap_pkg::DATA_W-1:0]    wr_data,
   input  wire logic [regmap_pkg::ADDR_W-1:0]    rd_addr,
   output logic      [regmap_pkg::DATA_W-1:0]    rd_data
);
   import regmap_pkg::*;
   logic [DATA_W-1:0] store [DEPTH];   // Word array, no reset so it maps to RAM
   // Write and registered read
   always_ff @(posedge clk) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
      rd_data <= store[rd_addr];
   end
endmodule // regmap_mem

//--- design/regmap_pkg.sv
// Package for the paged register map with configuration signature check.
// Assumes a single 25 MHz clock domain and synchronous pin inputs.
package regmap_pkg;
   localparam int unsigned DATA_W        = 14;
   localparam int unsigned ADDR_W        = 9;
   localparam int unsigned PAGE_W        = 3;
   localparam int unsigned OFFS_W        = ADDR_W - PAGE_W;
   localparam int unsigned DEPTH         = 1 << ADDR_W;
   localparam logic [2:0]  PAGE_MEAS     = 3'h1;
   localparam logic [2:0]  PAGE_CONFIG   = 3'h2;
   localparam logic [2:0]  PAGE_CMD      = 3'h3;
   localparam logic [2:0]  PAGE_INT_A    = 3'h4;
   localparam logic [2:0]  PAGE_INT_B    = 3'h5;
   localparam logic [8:0]  ADDR_NV_REF   = 9'h13e;
   localparam logic [8:0]  ADDR_NV_CALC  = 9'h13f;
   localparam logic [8:0]  ADDR_FAULT    = 9'h0a0;
   localparam int unsigned FAULT_SIG_BIT = 0;
   localparam int unsigned CONFIG_WORDS  = 1 << OFFS_W;
   localparam logic [13:0] MISR_SEED     = 14'h0000;
   localparam logic [13:0] MISR_POLY     = 14'h2a01;
   localparam logic [13:0] RESET_VALUE   = 14'h0000;
   localparam logic [5:0]  RESP_ACK_LEN  = 6'h04;
   localparam logic [5:0]  RESP_VOLT_LEN = 6'h28;
   localparam logic [5:0]  RESP_TEMP_LEN = 6'h16;
   typedef enum logic [2:0] {
      CMD_NONE, CMD_CALC, CMD_CHECK, CMD_RESET, CMD_RD_ONE, CMD_RD_VOLT, CMD_RD_TEMP, CMD_RD_FAULT
   } cmd_type;
endpackage

//--- verif/regmap_checksum_asserts.sv
// Port checker for regmap_checksum, bound after the module.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/100ps
module regmap_checksum_asserts
   import regmap_pkg::*;
(
   input wire logic                 clk,
   input wire logic                 resetn,
   input wire logic                 reset_cmd,
   input wire logic                 wr_en,
   input wire logic [8:0]           addr,
   input wire regmap_pkg::cmd_type  cmd,
   input wire logic                 rd_valid,
   input wire logic [5:0]           resp_len,
   input wire logic                 resp_valid,
   input wire logic                 nak,
   input wire logic                 busy,
   input wire logic                 register_integrity_fault_bit,
   input wire logic                 scan_en,
   input wire logic                 balance_en,
   input wire logic                 fault_notify
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire idle = !busy && !reset_cmd;             // A request is taken at this edge
   wire flt  = register_integrity_fault_bit;    // Short alias for the fault level
   wire wr1  = idle && cmd == CMD_NONE && wr_en; // Plain write taken
   // Signature walk: 68 busy cycles, then a four-byte acknowledge
   sequence s_walk;
      busy [*8] ##60 busy ##1 (!busy && resp_valid && resp_len == RESP_ACK_LEN);
   endsequence
   property p_sig; idle && (cmd == CMD_CALC || cmd == CMD_CHECK) |=> s_walk; endproperty
   a_sig: assert property (p_sig) else $error("signature walk timing wrong");
   property p_one; idle && cmd == CMD_RD_ONE |=> rd_valid && resp_len == RESP_ACK_LEN; endproperty
   a_one: assert property (p_one) else $error("single read response wrong");
   property p_volt; idle && cmd == CMD_RD_VOLT |=> resp_valid && resp_len == RESP_VOLT_LEN; endproperty
   a_volt: assert property (p_volt) else $error("voltage response length wrong");
   property p_temp; idle && (cmd == CMD_RD_TEMP || cmd == CMD_RD_FAULT) |=> resp_len == RESP_TEMP_LEN; endproperty
   a_temp: assert property (p_temp) else $error("temperature response length wrong");
   property p_nak; wr1 && addr[8:6] != PAGE_CONFIG |=> resp_valid && nak; endproperty
   a_nak: assert property (p_nak) else $error("write outside config not refused");
   property p_clr; wr1 && addr[8:6] == PAGE_CONFIG |=> !flt && !nak; endproperty
   a_clr: assert property (p_clr) else $error("config write did not clear fault");
   property p_note; $rose(flt) |-> fault_notify && resp_valid; endproperty
   a_note: assert property (p_note) else $error("fault raised without notification");
   property p_halt; flt |-> !scan_en && !balance_en; endproperty
   a_halt: assert property (p_halt) else $error("activity kept during fault");
endmodule // regmap_checksum_asserts
bind regmap_checksum regmap_checksum_asserts chk (.clk, .resetn, .reset_cmd, .wr_en, .addr, .cmd,
   .rd_valid, .resp_len, .resp_valid, .nak, .busy, .register_integrity_fault_bit, .scan_en, .balance_en,
   .fault_notify);

//--- verif/regmap_checksum_tb_top.sv
// Scenario bench for regmap_checksum, with writes routed through the host model.
// Assumes the map clears itself after every reset before it takes requests.
`timescale 1ns/100ps
module regmap_checksum_tb_top;
   import regmap_pkg::*;
   localparam logic [13:0] NV_REF = 14'h2c3d; // Arbitrary factory reference
   logic        clk = 0, resetn = 0, reset_cmd = 0, t_wr = 0, fix_en = 0, scan_req = 0, balance_req = 0;
   logic        wr_en, rd_valid, resp_valid, nak, busy, flt, fault_notify, scan_en, balance_en;
   logic [8:0]  addr, t_addr = 0;
   logic [13:0] wr_data, rd_data, t_data = 0, pin_levels = 0, pin_mask = 0;
   logic [5:0]  resp_len;
   cmd_type     cmd = CMD_NONE;
   int          fail_count = 0, n_checks = 0;
   always #20 clk = ~clk; // 25 MHz
   regmap_host_model host (.clk, .resetn, .fix_en, .fault(flt), .t_wr, .t_addr, .t_data, .wr_en, .addr, .wr_data);
   regmap_checksum uut (.clk, .resetn, .reset_cmd, .wr_en, .addr, .wr_data, .cmd, .nv_ref_value(NV_REF),
      .pin_levels, .pin_mask, .scan_req, .balance_req, .rd_data, .rd_valid, .resp_len, .resp_valid, .nak,
      .busy, .register_integrity_fault_bit(flt), .fault_notify, .scan_en, .balance_en);
   // Verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(string what, logic [13:0] exp, logic [13:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Reload signature: cleared config page, then the factory reference
   function automatic logic [13:0] nv_sum();
      logic [13:0] m;
      m = MISR_SEED;
      for (int k = 0; k < 65; k++) begin
         m = {m[12:0], 1'b0} ^ (m[13] ? MISR_POLY : 14'h0000) ^ ((k == 64) ? NV_REF : RESET_VALUE);
      end
      return m;
   endfunction
   // Bounded wait for an answer, or for the map to go idle
   task automatic wt(logic idle);
      for (int i = 0; i < 2000; i++) begin
         #1;
         if (idle ? busy === 1'b0 : resp_valid === 1'b1) return;
         @(posedge clk);
      end
      fail_count++;
      summarize();
   endtask
   // One request for one cycle, then wait for its answer
   task automatic req(cmd_type c, logic w, logic [8:0] a, logic [13:0] d);
      @(posedge clk);
      cmd <= c;
      t_wr <= w;
      t_addr <= a;
      t_data <= d;
      @(posedge clk);
      cmd <= CMD_NONE;
      t_wr <= 1'b0;
      wt(1'b0);
   endtask
   task automatic rd(logic [8:0] a, logic [13:0] e);
      req(CMD_RD_ONE, 1'b0, a, 14'h0000);
      chk("rd_valid", 1'b1, rd_valid);
      chk("rd_data", e, rd_data);
   endtask
   task automatic t_init();
      wt(1'b1);
      rd(9'h085, RESET_VALUE);
      rd(ADDR_NV_REF, NV_REF);
      rd(ADDR_NV_CALC, nv_sum());
      @(posedge clk);
      pin_mask <= 14'h0003;
      pin_levels <= 14'h0002;
      rd(9'h081, 14'h0002);
      @(posedge clk);
      pin_mask <= 14'h0000;
      $display("test init done");
   endtask
   task automatic t_write();
      logic [8:0] bad[5] = '{9'h040, 9'h0c0, 9'h100, ADDR_NV_REF, ADDR_NV_CALC};
      req(CMD_NONE, 1'b1, 9'h085, 14'h1abc);
      chk("nak", 1'b0, nak);
      rd(9'h085, 14'h1abc);
      foreach (bad[i]) begin
         req(CMD_NONE, 1'b1, bad[i], 14'h0001);
         chk("nak", 1'b1, nak);
      end
      rd(ADDR_NV_REF, NV_REF);
      $display("test write done");
   endtask
   task automatic t_len();
      cmd_type    cs[4] = '{CMD_RD_ONE, CMD_RD_VOLT, CMD_RD_TEMP, CMD_RD_FAULT};
      logic [5:0] ls[4] = '{RESP_ACK_LEN, RESP_VOLT_LEN, RESP_TEMP_LEN, RESP_TEMP_LEN};
      foreach (cs[i]) begin
         req(cs[i], 1'b0, 9'h085, 14'h0000);
         chk("resp_len", ls[i], resp_len);
      end
      $display("test lengths done");
   endtask
   task automatic t_sum();
      @(posedge clk);
      scan_req <= 1'b1;
      balance_req <= 1'b1;
      req(CMD_CALC, 1'b0, 9'h000, 14'h0000);
      chk("resp_len", RESP_ACK_LEN, resp_len);
      req(CMD_RD_VOLT, 1'b0, 9'h040, 14'h0000);
      req(CMD_NONE, 1'b1, 9'h0c0, 14'h0007);
      req(CMD_CHECK, 1'b0, 9'h000, 14'h0000);
      chk("fault", 1'b0, flt);
      chk("scan_en", 1'b1, scan_en);
      chk("balance_en", 1'b1, balance_en);
      req(CMD_NONE, 1'b1, 9'h090, 14'h0155);
      req(CMD_CHECK, 1'b0, 9'h000, 14'h0000);
      chk("fault", 1'b1, flt);
      chk("fault_notify", 1'b1, fault_notify);
      @(posedge clk);
      fix_en <= 1'b1;
      #1;
      chk("scan_en", 1'b0, scan_en);
      chk("balance_en", 1'b0, balance_en);
      for (int i = 0; i < 8 && flt !== 1'b0; i++) @(posedge clk) #1;
      chk("fault", 1'b0, flt);
      chk("scan_en", 1'b1, scan_en);
      repeat (64) @(posedge clk);
      rd(9'h090, 14'h0000);
      @(posedge clk);
      fix_en <= 1'b0;
      reset_cmd <= 1'b1;
      @(posedge clk);
      reset_cmd <= 1'b0;
      wt(1'b1);
      rd(9'h090, RESET_VALUE);
      rd(ADDR_NV_REF, NV_REF);
      rd(ADDR_NV_CALC, nv_sum());
      $display("test checksum done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      t_init();
      t_write();
      t_len();
      t_sum();
      summarize();
   end
endmodule // regmap_checksum_tb_top

//--- verif/regmap_host_model.sv
// Host-side model that passes bench writes on to the map and rewrites config after a fault.
// Assumes the bench drives its request fields at the rising clock edge.
`timescale 1ns/100ps
module regmap_host_model (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        fix_en,
   input  wire logic        fault,
   input  wire logic        t_wr,
   input  wire logic [8:0]  t_addr,
   input  wire logic [13:0] t_data,
   output logic             wr_en,
   output logic [8:0]       addr,
   output logic [13:0]      wr_data
);
   import regmap_pkg::*;
   logic       fix_reg;    // Config page rewrite in flight
   logic       fix_next;   // Next rewrite state
   logic [5:0] idx_reg;    // Config word being rewritten
   logic [5:0] idx_next;   // Next config word
   // One full page rewrite per fault; a fault still standing after it starts another
   always_comb begin
      fix_next = fix_reg;
      idx_next = idx_reg;
      if (fix_reg) begin
         idx_next = idx_reg + 6'h01;
         fix_next = (idx_reg != 6'h3f);
      end else if (fix_en && fault) begin
         fix_next = 1'b1;
         idx_next = 6'h00;
      end
   end
   // Register the rewrite progress
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fix_reg <= 1'b0;
         idx_reg <= 6'h00;
      end else begin
         fix_reg <= fix_next;
         idx_reg <= idx_next;
      end
   end
   // Every config word is written as zero, reserved bits included
   assign wr_en   = fix_reg | t_wr;
   assign addr    = fix_reg ? {PAGE_CONFIG, idx_reg} : t_addr;
   assign wr_data = fix_reg ? 14'h0000 : t_data;
endmodule // regmap_host_model
